/* File: dv/rsesq_trig_flash_src.sv */
`timescale 1ns/1ps
module rsesq_trig_flash_src (
  input wire logic clk,
  input wire logic strobe,
  output logic trigger,
  output logic lampOn,
  output int cyc,
  output int strobeFirst,
  output int strobeLen
);
  // trigger idles low, nothing seen yet
  initial begin
    trigger = 1'b0;
    lampOn = 1'b0;
    cyc = 0;
    strobeFirst = -1;
    strobeLen = 0;
  end

  // cycle count, zero at the accepted trigger edge
  always @(posedge clk) begin
    cyc <= cyc + 1;
  end

  // lamp lit over the whole strobe window, measure it
  always @(negedge clk) begin
    lampOn <= strobe;
    if (strobe === 1'b1) begin
      if (strobeLen == 0) strobeFirst <= cyc;
      strobeLen <= strobeLen + 1;
    end
  end

  // rising edge, level held w cycles; mark restarts the count
  task automatic fire(input int w, input bit mark);
    @(negedge clk);
    trigger = 1'b1;
    if (mark) begin
      cyc = -1;
      strobeFirst = -1;
      strobeLen = 0;
    end
    repeat (w) @(negedge clk);
    trigger = 1'b0;
  endtask : fire
endmodule : rsesq_trig_flash_src

/* File: dv/tb_top.sv */
`timescale 1ns/1ps
module tb_top import rsesq_pkg::*;;
  localparam int E = 4;
  localparam int L = 3;
  localparam int T = 8;
  logic clk, arst_n, trigger, shutterMode, strobe, lampOn;
  logic lineReset, globalReset, readStart, rowSend, busy, expTooShort;
  logic [CYC_W-1:0] lineCycles, exposureCycles, scanTime, minReadout, frameTime;
  logic [TICKS_W-1:0] flashTicks;
  logic [LINE_W-1:0] roiFirst, roiLast, resetLine, readLine;
  int cyc, strobeFirst, strobeLen, curX, nLR, nRS, nGR;
  int miscompares = 0;
  int checkCount = 0;

  // 200 MHz clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  rolling_shutter_exposure_sequencer #(.ACTIVE(6), .DUMMY(2), .EXP_DELAY(E)) DUT (
    .clk(clk), .arst_n(arst_n), .trigger(trigger), .shutterMode(shutterMode),
    .lineCycles(lineCycles), .exposureCycles(exposureCycles), .flashTicks(flashTicks),
    .roiFirst(roiFirst), .roiLast(roiLast), .lineReset(lineReset), .resetLine(resetLine),
    .globalReset(globalReset), .readStart(readStart), .readLine(readLine),
    .rowSend(rowSend), .strobe(strobe), .busy(busy), .expTooShort(expTooShort),
    .scanTime(scanTime), .minReadout(minReadout), .frameTime(frameTime)
  );

  rsesq_trig_flash_src src (
    .clk(clk), .strobe(strobe), .trigger(trigger), .lampOn(lampOn), .cyc(cyc),
    .strobeFirst(strobeFirst), .strobeLen(strobeLen)
  );

  task automatic chk_val(input logic [CYC_W-1:0] got, input logic [CYC_W-1:0] exp,
                         input string msg);
    checkCount++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t %s got %0h exp %0h", $time, msg, got, exp);
    end
  endtask : chk_val

  task automatic chk_cnt(input int got, input int exp, input string msg);
    checkCount++;
    if (got != exp) begin
      miscompares++;
      $display("[FAIL] %0t %s got %0d exp %0d", $time, msg, got, exp);
    end
  endtask : chk_cnt

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checkCount, miscompares);
    if (miscompares == 0 && checkCount > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : report_and_stop

  // per-line events timed against the accepted trigger edge
  always @(negedge clk) begin
    if (lineReset === 1'b1) begin
      chk_val(32'(resetLine), 32'(nLR), "reset line");
      chk_cnt(cyc, E + nLR * L, "reset time");
      nLR++;
    end
    if (globalReset === 1'b1) begin
      chk_cnt(cyc, E, "global reset time");
      nGR++;
    end
    if (readStart === 1'b1) begin
      chk_val(32'(readLine), 32'(nRS), "read line");
      chk_cnt(cyc, E + curX + nRS * L, "read time");
      chk_val(32'(rowSend), 32'(nRS >= 2 && nRS <= 5), "row send");
      nRS++;
    end
  end

  // one frame, optional second edge while busy, then judge it
  task automatic frame(input logic mode, input int x, input int fl, input int w,
                       input int sFirst, input int sLen, input bit again);
    int n;
    @(negedge clk);
    shutterMode = mode;
    exposureCycles = 32'(x);
    flashTicks = 16'(fl);
    curX = x;
    nLR = 0;
    nRS = 0;
    nGR = 0;
    src.fire(w, 1'b1);
    if (again) src.fire(2, 1'b0);
    for (n = 0; n < 400 && busy !== 1'b0; n++) @(negedge clk);
    if (n == 400) begin
      miscompares++;
      report_and_stop();
    end
    chk_cnt(nLR, mode ? 0 : T, "line resets");
    chk_cnt(nGR, mode ? 1 : 0, "global resets");
    chk_cnt(nRS, T, "reads");
    chk_cnt(strobeFirst, sFirst, "strobe start");
    chk_cnt(strobeLen, sLen, "strobe width");
    chk_val(frameTime, 32'(L * T + E + x), "frame time");
  endtask : frame

  task automatic scen_rolling_short_flash();
    frame(1'b0, 32, 2, 1, E + L * T, 2 * TICK_CYC, 1'b0);
    chk_val(32'(expTooShort), 32'h0, "too short flag");
  endtask : scen_rolling_short_flash

  task automatic scen_rolling_long_flash();
    frame(1'b0, 5, 10, 1, E, L * T + 5, 1'b0);
  endtask : scen_rolling_long_flash

  task automatic scen_grr();
    frame(1'b1, 10, 2, 15, E, 2 * TICK_CYC, 1'b0);
    frame(1'b1, 10, 5, 1, E, 10, 1'b0);
  endtask : scen_grr

  task automatic scen_refused_retrigger();
    frame(1'b0, 5, 0, 20, -1, 0, 1'b1);
    frame(1'b0, 5, 0, 1, -1, 0, 1'b0);
    frame(1'b1, 5, 0, 1, -1, 0, 1'b1);
  endtask : scen_refused_retrigger

  task automatic scen_too_short();
    frame(1'b0, 10, 2, 1, -1, 0, 1'b0);
    chk_val(32'(expTooShort), 32'h1, "too short flag");
  endtask : scen_too_short

  task automatic scen_scan_live();
    chk_val(scanTime, 32'(L * T), "scan time");
    chk_val(minReadout, 32'(L * T + E), "min readout");
    @(negedge clk);
    lineCycles = 32'h5;
    repeat (3) @(negedge clk);
    chk_val(scanTime, 32'(5 * T), "scan time live");
    chk_val(minReadout, 32'(5 * T + E), "min readout live");
    lineCycles = 32'h3;
    repeat (3) @(negedge clk);
  endtask : scen_scan_live

  // reset, then the scenarios in turn
  initial begin
    arst_n = 1'b0;
    shutterMode = 1'b0;
    lineCycles = 32'h3;
    exposureCycles = 32'h5;
    flashTicks = 16'h0;
    roiFirst = 12'h2;
    roiLast = 12'h7;
    repeat (2) @(posedge clk);
    @(negedge clk);
    arst_n = 1'b1;
    repeat (4) @(negedge clk);
    scen_rolling_short_flash();
    scen_scan_live();
    scen_rolling_long_flash();
    scen_grr();
    scen_refused_retrigger();
    scen_too_short();
    report_and_stop();
  end
endmodule : tb_top

/* File: hw/rolling_shutter_exposure_sequencer.sv */
`timescale 1ns/1ps
module rolling_shutter_exposure_sequencer import rsesq_pkg::*; #(
  parameter int LW = LINE_W,
  parameter int CW = CYC_W,
  parameter int ACTIVE = ACTIVE_LINES_DEF,
  parameter int DUMMY = DUMMY_LINES_DEF,
  parameter int EXP_DELAY = EXP_DELAY_CYC
)(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic trigger,
  input wire logic shutterMode,
  input wire logic [CW-1:0] lineCycles,
  input wire logic [CW-1:0] exposureCycles,
  input wire logic [TICKS_W-1:0] flashTicks,
  input wire logic [LW-1:0] roiFirst,
  input wire logic [LW-1:0] roiLast,
  output logic lineReset,
  output logic [LW-1:0] resetLine,
  output logic globalReset,
  output logic readStart,
  output logic [LW-1:0] readLine,
  output logic rowSend,
  output logic strobe,
  output logic busy,
  output logic expTooShort,
  output logic [CW-1:0] scanTime,
  output logic [CW-1:0] minReadout,
  output logic [CW-1:0] frameTime
);
  localparam logic [LW-1:0] TOTAL = LW'(ACTIVE + DUMMY);
  localparam logic [LW-1:0] ACT = LW'(ACTIVE);
  localparam logic [CW-1:0] DLY = CW'(EXP_DELAY);

  function automatic logic [CW-1:0] minc(input logic [CW-1:0] a, input logic [CW-1:0] b);
    minc = (a < b) ? a : b;
  endfunction : minc

  function automatic logic [CW-1:0] lineSpan(input logic [CW-1:0] lc, input logic [LW-1:0] n);
    lineSpan = CW'(lc * CW'(n));
  endfunction : lineSpan

  logic [1:0] rstPipe;
  logic rst_n;
  rsesq_state_t state;
  logic trigPrev;
  logic trigEdge;
  logic modeLat;
  logic [CW-1:0] expLat;
  logic [CW-1:0] lineLat;
  logic [CW-1:0] stbDelay;
  logic [CW-1:0] stbStop;
  logic [CW-1:0] cnt;
  logic leadEnd;
  logic integEnd;
  logic rsStep, rsDone, rsBusy;
  logic [LW-1:0] rsIdx;
  logic rdStep, rdDone, rdBusy;
  logic [LW-1:0] rdIdx;
  logic [CW-1:0] scanNow;
  logic [CW-1:0] expNow;
  logic [CW-1:0] flashCyc;
  logic shortFlash;
  logic [CW-1:0] next_stbDelay;
  logic [CW-1:0] next_stbStop;
  logic [CW-1:0] frameLen;
  logic [CW-1:0] frameLat;

  // reset release through two flops
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rstPipe <= 2'h0;
    end else begin
      rstPipe <= {rstPipe[0], 1'h1};
    end
  end
  assign rst_n = rstPipe[1];

  // timing from current line setup
  assign scanNow = lineSpan(lineCycles, TOTAL);
  assign expNow = (exposureCycles == '0) ? CW'(1) : exposureCycles;
  assign flashCyc = CW'(flashTicks) * CW'(TICK_CYC);
  assign shortFlash = flashCyc < scanNow;

  // strobe window relative to exposure start
  always_comb begin
    next_stbDelay = '0;
    next_stbStop = minc(flashCyc, expNow);
    if (shutterMode == MODE_ROLLING) begin
      if (shortFlash) begin
        next_stbDelay = scanNow;
        next_stbStop = minc(scanNow + flashCyc, expNow);
      end else begin
        next_stbStop = scanNow + expNow;
      end
    end
  end

  // frame length figures, refreshed every cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scanTime <= '0;
      minReadout <= '0;
      frameTime <= '0;
      expTooShort <= 1'h0;
    end else begin
      scanTime <= scanNow;
      minReadout <= scanNow + DLY;
      frameTime <= scanNow + DLY + expNow;
      expTooShort <= (shutterMode == MODE_ROLLING) && shortFlash && (flashCyc != '0)
                     && (expNow < scanNow + flashCyc);
    end
  end

  // trigger rising edge only starts a frame
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      trigPrev <= 1'h0;
    end else begin
      trigPrev <= trigger;
    end
  end
  assign trigEdge = trigger && !trigPrev && (state == RSESQ_IDLE);

  // settings captured per frame
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      modeLat <= MODE_ROLLING;
      expLat <= CW'(1);
      lineLat <= CW'(1);
      stbDelay <= '0;
      stbStop <= '0;
      frameLat <= '0;
    end else if (trigEdge) begin
      modeLat <= shutterMode;
      expLat <= expNow;
      lineLat <= lineCycles;
      stbDelay <= next_stbDelay;
      stbStop <= next_stbStop;
      frameLat <= scanNow + DLY + expNow;
    end
  end

  assign leadEnd = (state == RSESQ_LEAD) && (cnt == DLY - CW'(1));
  assign integEnd = (state == RSESQ_INTEG) && (cnt == expLat - CW'(1));

  // frame sequence: delay, integrate, read out
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= RSESQ_IDLE;
      cnt <= '0;
    end else begin
      unique case (state)
        RSESQ_IDLE: begin
          cnt <= '0;
          if (trigEdge) begin
            state <= RSESQ_LEAD;
          end
        end
        RSESQ_LEAD: begin
          cnt <= leadEnd ? '0 : cnt + CW'(1);
          if (leadEnd) begin
            state <= RSESQ_INTEG;
          end
        end
        RSESQ_INTEG: begin
          cnt <= integEnd ? '0 : cnt + CW'(1);
          if (integEnd) begin
            state <= RSESQ_READ;
          end
        end
        RSESQ_READ: begin
          if (rdDone) begin
            state <= RSESQ_IDLE;
          end
        end
      endcase
    end
  end

  // line reset walker, rolling mode only
  rsesq_line_step #(.LW(LW), .CW(CW)) uResetStep (
    .clk(clk),
    .rst_n(rst_n),
    .start(leadEnd && (modeLat == MODE_ROLLING)),
    .lineCycles(lineLat),
    .lineCount(TOTAL),
    .step(rsStep),
    .idx(rsIdx),
    .done(rsDone),
    .busy(rsBusy)
  );

  // readout walker, same pitch so each line gets equal exposure in rolling mode
  rsesq_line_step #(.LW(LW), .CW(CW)) uReadStep (
    .clk(clk),
    .rst_n(rst_n),
    .start(integEnd),
    .lineCycles(lineLat),
    .lineCount(TOTAL),
    .step(rdStep),
    .idx(rdIdx),
    .done(rdDone),
    .busy(rdBusy)
  );

  // flash timer starts with exposure
  rsesq_strobe #(.CW(CW)) uStrobe (
    .clk(clk),
    .rst_n(rst_n),
    .start(leadEnd),
    .delayCyc(stbDelay),
    .stopCyc(stbStop),
    .strobe(strobe)
  );

  // registered sensor control outputs
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lineReset <= 1'h0;
      resetLine <= '0;
      globalReset <= 1'h0;
      readStart <= 1'h0;
      readLine <= '0;
      rowSend <= 1'h0;
      busy <= 1'h0;
    end else begin
      lineReset <= rsStep && (modeLat == MODE_ROLLING);
      resetLine <= rsIdx;
      globalReset <= leadEnd && (modeLat == MODE_GRR);
      readStart <= rdStep;
      readLine <= rdIdx;
      rowSend <= rdStep && (rdIdx >= roiFirst) && (rdIdx <= roiLast) && (rdIdx < ACT);
      busy <= (state != RSESQ_IDLE) || trigEdge;
    end
  end

  // cycles since the frame was accepted, for checking
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      frameLen <= '0;
    end else if (trigEdge) begin
      frameLen <= '0;
    end else if (state != RSESQ_IDLE) begin
      frameLen <= frameLen + CW'(1);
    end
  end

  rst_reset_pitch_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    lineReset |-> frameLen == DLY + CW'(lineLat * CW'(resetLine)))
    else $error("line reset off its pitch");

  read_after_exp_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    readStart |-> frameLen == DLY + expLat + CW'(lineLat * CW'(readLine)))
    else $error("readout not at end of exposure");

  reinteg_wait_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    lineReset |-> !(rdBusy && uReadStep.line == resetLine))
    else $error("reset while readout busy");

  grr_wait_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    $rose(globalReset) |-> !rdBusy && !$past(rdBusy))
    else $error("global reset during readout");

  frame_length_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    rdDone |-> frameLen == frameLat - CW'(1))
    else $error("frame time mismatch");

  mode_reset_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    globalReset |-> modeLat == MODE_GRR && !lineReset ##1 !globalReset)
    else $error("global reset in wrong mode");

  grr_strobe_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    (globalReset && stbStop != '0) |-> strobe)
    else $error("strobe not with exposure");

  strobe_end_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    (readStart && readLine == '0 && modeLat == MODE_GRR) |-> !strobe)
    else $error("strobe past exposure end");

  roi_gate_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    rowSend |-> readStart && readLine >= roiFirst && readLine <= roiLast)
    else $error("row sent outside region");

  read_order_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    (readStart && readLine != '0) |-> readLine == uReadStep.line)
    else $error("readout order broken");
endmodule : rolling_shutter_exposure_sequencer

/* File: hw/rsesq_line_step.sv */
`timescale 1ns/1ps
module rsesq_line_step import rsesq_pkg::*; #(
  parameter int LW = LINE_W,
  parameter int CW = CYC_W
)(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic [CW-1:0] lineCycles,
  input wire logic [LW-1:0] lineCount,
  output logic step,
  output logic [LW-1:0] idx,
  output logic done,
  output logic busy
);
  logic [CW-1:0] cnt;
  logic [LW-1:0] line;
  logic wrap;
  logic last;

  // one line slot ends after lineCycles clocks
  assign wrap = busy && (cnt == lineCycles - CW'(1));
  assign last = (line == lineCount - LW'(1));
  assign step = start || (wrap && !last);
  assign idx = start ? '0 : line + LW'(1);
  assign done = wrap && last;

  // walk one line per slot
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy <= 1'h0;
      cnt <= '0;
      line <= '0;
    end else if (start) begin
      busy <= 1'h1;
      cnt <= '0;
      line <= '0;
    end else if (wrap) begin
      cnt <= '0;
      if (last) begin
        busy <= 1'h0;
      end else begin
        line <= line + LW'(1);
      end
    end else if (busy) begin
      cnt <= cnt + CW'(1);
    end
  end
endmodule : rsesq_line_step

/* File: hw/rsesq_strobe.sv */
`timescale 1ns/1ps
module rsesq_strobe import rsesq_pkg::*; #(
  parameter int CW = CYC_W
)(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic [CW-1:0] delayCyc,
  input wire logic [CW-1:0] stopCyc,
  output logic strobe
);
  logic run;
  logic [CW-1:0] cnt;
  logic [CW-1:0] c;
  logic next_strobe;

  // offset from exposure start, zero in the start cycle
  assign c = start ? '0 : cnt;
  assign next_strobe = (start || run) && (c >= delayCyc) && (c < stopCyc);

  // cycle timer, three counts per strobe tick
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      run <= 1'h0;
      cnt <= '0;
    end else if (start) begin
      run <= 1'h1;
      cnt <= CW'(1);
    end else if (run) begin
      cnt <= cnt + CW'(1);
      if (cnt >= stopCyc) begin
        run <= 1'h0;
      end
    end
  end

  // registered flash output
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      strobe <= 1'h0;
    end else begin
      strobe <= next_strobe;
    end
  end
endmodule : rsesq_strobe

/* File: pkg/rsesq_pkg.sv */
package rsesq_pkg;
  // clock and strobe tick timing
  localparam int CLK_PERIOD_PS = 5000;
  localparam int TICK_PS = 15000;
  localparam int TICK_CYC = (TICK_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // worst case delay from frame start to first line reset
  localparam int EXP_DELAY_US = 300;
  localparam int EXP_DELAY_CYC = (EXP_DELAY_US * 1000000) / CLK_PERIOD_PS;
  // sensor geometry
  localparam int ACTIVE_LINES_DEF = 3672;
  localparam int DUMMY_LINES_DEF = 54;
  localparam int LINE_W = 12;
  localparam int CYC_W = 32;
  localparam int TICKS_W = 16;
  // shutter setting encoding
  localparam logic MODE_ROLLING = 1'h0;
  localparam logic MODE_GRR = 1'h1;

  typedef enum logic [1:0] {
    RSESQ_IDLE,
    RSESQ_LEAD,
    RSESQ_INTEG,
    RSESQ_READ
  } rsesq_state_t;
endpackage : rsesq_pkg
